/* verilog/bsc_pkg.sv */
// Purpose: constants for the carry, shift and test-condition control
// Assumes: one 40 MHz clock, classic Wishbone slave, 16-bit datapath
// Notes: carries and shift lines in the datapath are active low
//
// Contract
// - word-select field steers shift mux and makes both active-low byte selects.
// - low left select stops right-byte clock; low right select stops left-byte clock.
// - carry bit 0 means carry-in or one-fill; 1 means none or zero-fill.
// - carry bit feeds right byte directly; left byte via word look-ahead.
// - function 00111 plus select bit is a one-bit right shift of T or AC.
// - shift code decoded into a flag that zeroes both byte carry muxes.
// - slice shift outputs drive only while a right shift is commanded.
// - right-byte-only op forces left carry mux to pass the right carry.
// - right-byte test equals right generate and (right propagate or carry bit).
// - without shift command the selected shift output reads 0.
// - third word stage gets fixed 1 and shift output; test = shift or stage-two carry.
// - test flop captures the condition each microcycle and feeds branching.
// - left-byte-only op forces right carry mux so carry bit reaches left byte.
// - left-byte test equals left generate and (left propagate or carry bit).
// - full word: both selects high; left carry-in from right terms and carry bit.
// - full word: third stage passes stage-two carry; test from left terms.
// - each right shift moves one bit; low bit out, high bit from shift input.
// - zero mask gives plain right shift; nonzero mask gives masked shift.
// - each byte look-ahead forms three inter-slice carries from cin, x, y.
// - conditional-clock bit stops register clocks, only test flop updates.

package bsc_pkg;
    localparam int DATA_W = 16;
    localparam int SLICES = 8;
    localparam logic [1:0] WS_WORD = 2'h0;
    localparam logic [1:0] WS_WORD_SHIFT = 2'h1;
    localparam logic [1:0] WS_LEFT = 2'h2;
    localparam logic [1:0] WS_RIGHT = 2'h3;
    localparam logic [4:0] FN_SHIFT = 5'h07;
    localparam logic [7:0] ADR_AC = 8'h00;
    localparam logic [7:0] ADR_T = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_CTRL = 8'h0C;
    localparam int ST_TEST = 0;
    localparam int ST_SHIFT = 1;
    localparam int ST_RSEL_N = 2;
    localparam int ST_LSEL_N = 3;
    localparam int ST_COND_N = 4;
    localparam int CTRL_HOLD = 0;
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [15:0] REG_RESET = 16'h0000;
endpackage

/* verilog/bsc_lookahead.sv */
// Purpose: four-stage look-ahead carry generator, active-low carries
// Assumes: x and y active high from the stages, cin_n active low
// Notes: group outputs ignore cin_n, so cascades route cin_n to each

`timescale 1ns/1ps

module bsc_lookahead
(
    input wire logic [3:0] x_i,
    input wire logic [3:0] y_i,
    input wire logic cin_n_i,
    output logic [2:0] c_n_o,
    output logic gx_o,
    output logic gy_o
);
    // stage carries chain through each other; pure logic
    assign c_n_o[0] = y_i[0] & (x_i[0] | cin_n_i);
    assign c_n_o[1] = y_i[1] & (x_i[1] | c_n_o[0]);
    assign c_n_o[2] = y_i[2] & (x_i[2] | c_n_o[1]);
    assign gx_o = |x_i;
    assign gy_o = y_i[3] & (x_i[3] | (x_i[2] & y_i[2]) | (x_i[1] & y_i[1] & y_i[2])
                  | (y_i[0] & y_i[1] & y_i[2]));
endmodule

/* verilog/bsc_top.sv */
// Purpose: byte/word carry, shift and test control around 2-bit slices
// Assumes: microinstruction fields come from logic on clk_i, held per step
// Notes: step_i marks the microcycle edge; software sees AC, T, status
//
// Implementation choices: the Wishbone register port and the placing of the registers.

`timescale 1ns/1ps

module bsc_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic step_i,
    input wire logic cond_clock_i,
    input wire logic [6:0] func_i,
    input wire logic [1:0] word_sel_i,
    input wire logic carry_bit_i,
    input wire logic [15:0] mask_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic test_flop_q_o
);
    localparam int W = bsc_pkg::DATA_W;
    localparam int NS = bsc_pkg::SLICES;

    logic [W-1:0] ac_r;
    logic [W-1:0] ac_nxt;
    logic [W-1:0] t_r;
    logic [W-1:0] t_nxt;
    logic hold_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic test_r;

    // microinstruction decode
    wire shift_command_flag;
    wire left_half_select_n;
    wire right_half_select_n;
    wire sel_ac;
    wire mask_zero;
    // 0 on the fill bit means one-fill, active-low line
    assign shift_command_flag = (func_i[6:2] == bsc_pkg::FN_SHIFT);
    assign sel_ac = func_i[0];
    assign left_half_select_n = (word_sel_i != bsc_pkg::WS_LEFT);
    assign right_half_select_n = (word_sel_i != bsc_pkg::WS_RIGHT);
    assign mask_zero = (mask_i == '0);

    // slice datapath
    wire [W-1:0] opnd;
    wire [W-1:0] shift_src;
    wire [NS-1:0] x_s;
    wire [NS-1:0] y_s;
    wire [NS-1:0] cin_n_s;
    wire [NS-1:0] slice_shift_out_n;
    wire [NS-1:0] slice_shift_in_n;
    wire [NS-1:0] slice_shift_oe;
    wire [W-1:0] res;
    wire [2:0] rc_n;
    wire [2:0] lc_n;
    wire [2:0] wc_n;
    wire right_half_propagate;
    wire right_half_generate;
    wire left_half_propagate;
    wire left_half_generate;
    wire right_propagate_muxed;
    wire right_generate_muxed;
    wire left_propagate_muxed;
    wire left_generate_muxed;
    wire left_half_carry_in_n;
    wire test_condition_n;
    wire selected_shift_out;
    wire right_half_shift_out_n;
    wire left_half_shift_out_n;
    wire right_left_in_n;

    assign opnd = sel_ac ? ac_r : t_r;
    // masked shift combines the mask before shifting
    assign shift_src = mask_zero ? opnd : (opnd & mask_i);

    genvar i;
    generate
        for (i = 0; i < NS; i++)
        begin : g_slice
            wire [1:0] a;
            wire [1:0] b;
            wire [2:0] sum;
            wire [2:0] raw;
            assign a = opnd[2*i+1:2*i];
            assign b = mask_i[2*i+1:2*i];
            assign raw = {1'b0, a} + {1'b0, b};
            assign sum = raw + {2'b00, ~cin_n_s[i]};
            // active-high x/y mean "no propagate" and "no generate"
            assign y_s[i] = ~raw[2];
            assign x_s[i] = ~(&(a | b));
            // shift out only drives during a shift, else pulled high
            assign slice_shift_oe[i] = shift_command_flag;
            assign slice_shift_out_n[i] = slice_shift_oe[i] ? ~shift_src[2*i] : 1'b1;
            // one bit per step: low bit out, high bit from shift
            assign res[2*i+1:2*i] = shift_command_flag
                ? {~slice_shift_in_n[i], shift_src[2*i+1]} : sum[1:0];
            if ((i % 4) == 3)
            begin : g_top
                // byte msb input: fill bit for left, mux output for right
                assign slice_shift_in_n[i] = (i == NS-1) ? carry_bit_i : right_left_in_n;
            end
            else
            begin : g_mid
                assign slice_shift_in_n[i] = slice_shift_out_n[i+1];
            end
            if ((i % 4) == 0)
            begin : g_lsb
                // carry bit direct to right byte, left via word stage
                assign cin_n_s[i] = (i == 0) ? carry_bit_i : left_half_carry_in_n;
            end
            else
            begin : g_ic
                assign cin_n_s[i] = (i < 4) ? rc_n[(i%4)-1] : lc_n[(i%4)-1];
            end
        end
    endgenerate

    // byte look-ahead generators
    bsc_lookahead u_right
    (
        .x_i(x_s[3:0]),
        .y_i(y_s[3:0]),
        .cin_n_i(carry_bit_i),
        .c_n_o(rc_n),
        .gx_o(right_half_propagate),
        .gy_o(right_half_generate)
    );

    bsc_lookahead u_left
    (
        .x_i(x_s[7:4]),
        .y_i(y_s[7:4]),
        .cin_n_i(left_half_carry_in_n),
        .c_n_o(lc_n),
        .gx_o(left_half_propagate),
        .gy_o(left_half_generate)
    );

    // carry muxes: forced to pass-through for single-byte ops, zero on shift
    assign right_propagate_muxed = shift_command_flag ? 1'b0
        : (!left_half_select_n ? 1'b0 : right_half_propagate);
    assign right_generate_muxed = shift_command_flag ? 1'b0
        : (!left_half_select_n ? 1'b1 : right_half_generate);
    assign left_propagate_muxed = shift_command_flag ? 1'b0
        : (!right_half_select_n ? 1'b0 : left_half_propagate);
    assign left_generate_muxed = shift_command_flag ? 1'b0
        : (!right_half_select_n ? 1'b1 : left_half_generate);

    // right shift mux
    assign right_half_shift_out_n = slice_shift_out_n[0];
    assign left_half_shift_out_n = slice_shift_out_n[4];
    assign right_left_in_n = (word_sel_i == bsc_pkg::WS_RIGHT)
        ? carry_bit_i : left_half_shift_out_n;
    assign selected_shift_out = (word_sel_i == bsc_pkg::WS_LEFT)
        ? ~left_half_shift_out_n : ~right_half_shift_out_n;

    // word stage: byte link, and fixed 1 with shift output on stage three
    bsc_lookahead u_word
    (
        .x_i({1'b0, selected_shift_out, left_propagate_muxed, right_propagate_muxed}),
        .y_i({1'b1, 1'b1, left_generate_muxed, right_generate_muxed}),
        .cin_n_i(carry_bit_i),
        .c_n_o(wc_n),
        .gx_o(),
        .gy_o()
    );
    assign left_half_carry_in_n = wc_n[0];
    assign test_condition_n = wc_n[2];

    // byte clock gating; register writes only on the byte's enabled step
    wire step_en;
    wire right_half_clock_en;
    wire left_half_clock_en;
    assign step_en = step_i & ~hold_r;
    assign right_half_clock_en = step_en & left_half_select_n & ~cond_clock_i;
    assign left_half_clock_en = step_en & right_half_select_n & ~cond_clock_i;

    // wishbone decode; one-cycle answer, unmapped reads zero
    wire req;
    wire wr;
    wire hit_ac;
    wire hit_t;
    wire hit_st;
    wire hit_ctl;
    wire [7:0] wr_lane_lo;
    wire [31:0] status_word;
    wire [31:0] rd_data;
    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    // writes land on the edge that samples ack, while the master still holds
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    assign hit_ac = (wb_adr_i == bsc_pkg::ADR_AC);
    assign hit_t = (wb_adr_i == bsc_pkg::ADR_T);
    assign hit_st = (wb_adr_i == bsc_pkg::ADR_STATUS);
    assign hit_ctl = (wb_adr_i == bsc_pkg::ADR_CTRL);
    assign wr_lane_lo = wb_dat_i[7:0];

    assign status_word = {27'h0000000, cond_clock_i ? 1'b0 : 1'b1,
        left_half_select_n, right_half_select_n, shift_command_flag, test_r};
    assign rd_data = hit_ac ? {16'h0000, ac_r}
        : hit_t ? {16'h0000, t_r}
        : hit_st ? status_word
        : hit_ctl ? {31'h00000000, hold_r}
        : 32'h00000000;

    // bus writes win over a datapath step in the same cycle
    assign ac_nxt[7:0] = (wr & hit_ac & wb_sel_i[0]) ? wr_lane_lo
        : (right_half_clock_en & sel_ac) ? res[7:0] : ac_r[7:0];
    assign ac_nxt[15:8] = (wr & hit_ac & wb_sel_i[1]) ? wb_dat_i[15:8]
        : (left_half_clock_en & sel_ac) ? res[15:8] : ac_r[15:8];
    assign t_nxt[7:0] = (wr & hit_t & wb_sel_i[0]) ? wr_lane_lo
        : (right_half_clock_en & ~sel_ac) ? res[7:0] : t_r[7:0];
    assign t_nxt[15:8] = (wr & hit_t & wb_sel_i[1]) ? wb_dat_i[15:8]
        : (left_half_clock_en & ~sel_ac) ? res[15:8] : t_r[15:8];

    // only these registers hold state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ac_r <= bsc_pkg::REG_RESET;
            t_r <= bsc_pkg::REG_RESET;
            hold_r <= bsc_pkg::CTRL_RESET;
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
            test_r <= 1'b0;
        end
        else
        begin
            ac_r <= ac_nxt;
            t_r <= t_nxt;
            ack_r <= req;
            if (req)
            begin
                dat_r <= rd_data;
            end
            if (wr & hit_ctl & wb_sel_i[0])
            begin
                hold_r <= wb_dat_i[bsc_pkg::CTRL_HOLD];
            end
            // test flop is clocked even when cond_clock_i inhibits register clocks; hold_r stops it too
            if (step_en)
            begin
                test_r <= ~test_condition_n;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign test_flop_q_o = test_r;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ws_select_decode: assert property (
        (left_half_select_n == (word_sel_i != 2'h2))
        && (right_half_select_n == (word_sel_i != 2'h3)))
        else $error("byte selects wrong for word select");

    a_right_clock_gate: assert property (
        step_en && !left_half_select_n && !(wr && hit_ac) && !(wr && hit_t)
        |=> $stable(ac_r[7:0]) && $stable(t_r[7:0]))
        else $error("right byte changed while left-only");

    a_left_clock_gate: assert property (
        step_en && !right_half_select_n && !(wr && hit_ac) && !(wr && hit_t)
        |=> $stable(ac_r[15:8]) && $stable(t_r[15:8]))
        else $error("left byte changed while right-only");

    a_shift_mux_off: assert property (
        shift_command_flag |-> !right_propagate_muxed && !right_generate_muxed
        && !left_propagate_muxed && !left_generate_muxed)
        else $error("carry mux active during shift");

    a_no_shift_out: assert property (
        !shift_command_flag |-> !selected_shift_out && (test_condition_n == wc_n[1]))
        else $error("shift output active without shift");

    a_right_byte_test: assert property (
        !shift_command_flag && word_sel_i == 2'h3 |-> test_condition_n ==
        (right_half_generate & (right_half_propagate | carry_bit_i)))
        else $error("right byte test condition wrong");

    a_left_byte_test: assert property (
        !shift_command_flag && word_sel_i == 2'h2 |-> test_condition_n ==
        (left_half_generate & (left_half_propagate | carry_bit_i)))
        else $error("left byte test condition wrong");

    a_word_test: assert property (
        !shift_command_flag && word_sel_i == 2'h0 |-> (test_condition_n ==
        (left_half_generate & (left_half_propagate | left_half_carry_in_n)))
        && (left_half_carry_in_n ==
        (right_half_generate & (right_half_propagate | carry_bit_i))))
        else $error("word test or left carry-in wrong");

    a_shift_test: assert property (
        shift_command_flag |-> test_condition_n == selected_shift_out)
        else $error("shift test condition wrong");

    a_test_capture: assert property (
        step_en |=> test_flop_q_o == !$past(test_condition_n))
        else $error("test flop missed condition");

    a_cond_hold: assert property (
        step_en && cond_clock_i && !wr
        |=> $stable(ac_r) && $stable(t_r))
        else $error("register clocked under inhibit");

    a_word_selects_high: assert property (
        word_sel_i == bsc_pkg::WS_WORD |-> left_half_select_n && right_half_select_n)
        else $error("byte selects not both high for word op");

    a_left_only_cin: assert property (
        !shift_command_flag && word_sel_i == bsc_pkg::WS_LEFT
        |-> left_half_carry_in_n == carry_bit_i)
        else $error("carry bit not passed to left byte");

    a_right_only_pass: assert property (
        !shift_command_flag && word_sel_i == bsc_pkg::WS_RIGHT
        |-> wc_n[1] == wc_n[0])
        else $error("right byte carry not passed through");

    a_shift_out_idle: assert property (
        !shift_command_flag |-> &slice_shift_out_n)
        else $error("slice shift output driven without shift");

    a_hold_freeze: assert property (
        hold_r && !wr |=> $stable(ac_r) && $stable(t_r) && $stable(test_r))
        else $error("state changed while steps frozen");

    sequence s_word_shift;
        step_en && shift_command_flag && sel_ac && mask_zero && !cond_clock_i
        && word_sel_i == 2'h1 && !wr;
    endsequence

    a_shift_one_bit: assert property (
        s_word_shift |=> ac_r == {~$past(carry_bit_i), $past(ac_r[15:1])})
        else $error("word shift not exactly one bit");
endmodule

/* dv/bsc_useq_model.sv */
// Purpose: microinstruction register model feeding the carry/shift control
// Assumes: bench asks for one microinstruction at a time on issue_i
// Notes: fields stay held after the step, as a real microinstruction register would

`timescale 1ns/1ps

module bsc_useq_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic issue_i,
    input wire logic [10:0] uword_i,
    input wire logic [15:0] mask_i,
    output logic step_o,
    output logic cond_clock_o,
    output logic [6:0] func_o,
    output logic [1:0] word_sel_o,
    output logic carry_bit_o,
    output logic [15:0] mask_o
);
    // step is one cycle wide, rising on the same edge the fields load
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            step_o <= 1'b0;
            {cond_clock_o, func_o, word_sel_o, carry_bit_o} <= 11'h000;
            mask_o <= 16'h0000;
        end
        else
        begin
            step_o <= issue_i;
            if (issue_i)
            begin
                {cond_clock_o, func_o, word_sel_o, carry_bit_o} <= uword_i;
                mask_o <= mask_i;
            end
        end
    end
endmodule

/* dv/test_bitslice_carry_shift_control.sv */
// Purpose: self-checking bench for the carry, shift and test-condition control
// Assumes: one 40 MHz clock, classic Wishbone register access
// Notes: results are read back over the bus; the test flop is also read directly

`timescale 1ns/1ps

module test_bitslice_carry_shift_control;
    localparam logic [6:0] SH_AC = 7'h1D;
    localparam logic [6:0] SH_T = 7'h1C;
    localparam logic [6:0] AD_AC = 7'h01;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic issue = 1'b0;
    logic [10:0] uword = 11'h000;
    logic [15:0] umask = 16'h0000;
    logic step, cond_clock, carry_bit, wb_ack, tf_q;
    logic [6:0] func;
    logic [1:0] word_sel;
    logic [15:0] mask;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h00000000;
    logic [31:0] wb_rdat;
    int err_total = 0;
    int cmp_count = 0;
    int cyc_n = 0;

    always #12.5 clk_i = ~clk_i;

    bsc_useq_model u_seq (.clk_i(clk_i), .rst_i(rst_i), .issue_i(issue), .uword_i(uword),
        .mask_i(umask), .step_o(step), .cond_clock_o(cond_clock), .func_o(func),
        .word_sel_o(word_sel), .carry_bit_o(carry_bit), .mask_o(mask));

    bsc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .step_i(step), .cond_clock_i(cond_clock),
        .func_i(func), .word_sel_i(word_sel), .carry_bit_i(carry_bit), .mask_i(mask),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'h3), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .test_flop_q_o(tf_q));

    task automatic end_sim();
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // a hung bus or step ends the run through the same verdict
    always @(posedge clk_i)
    begin
        cyc_n = cyc_n + 1;
        if (cyc_n == 5000)
        begin
            err_total = err_total + 1;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_total = err_total + 1;
        end
    endtask

    // holds the request until ack is sampled high, then releases
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        @(posedge clk_i);
        while (wb_ack !== 1'b1)
            @(posedge clk_i);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [15:0] d);
        logic [31:0] rd;
        wb_xfer(1'b1, adr, {16'h0000, d}, rd);
    endtask

    task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_xfer(1'b0, adr, 32'h00000000, rd);
        chk(name, exp, rd);
    endtask

    // one microinstruction: cond, func, word select, carry bit, then mask bus
    task automatic uop(input logic c, input logic [6:0] f, input logic [1:0] ws,
        input logic cb, input logic [15:0] m);
        @(posedge clk_i);
        issue <= 1'b1;
        uword <= {c, f, ws, cb};
        umask <= m;
        @(posedge clk_i);
        issue <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("ac_reset", bsc_pkg::ADR_AC, 32'h00000000);
        rdchk("t_reset", bsc_pkg::ADR_T, 32'h00000000);
        rdchk("ctrl_reset", bsc_pkg::ADR_CTRL, 32'h00000000);
        rdchk("status_word", bsc_pkg::ADR_STATUS, 32'h0000001C);
        rdchk("unmapped", 8'h10, 32'h00000000);
        // shift out is active low, so the flop ends up holding the inverse low bit
        wr(bsc_pkg::ADR_AC, 16'h0003);
        uop(1'b0, SH_AC, 2'h1, 1'b0, 16'h0000);
        rdchk("ac_shift_one_fill", bsc_pkg::ADR_AC, 32'h00008001);
        chk("tf_low_bit", 32'h0, {31'h0, tf_q});
        rdchk("status_shift", bsc_pkg::ADR_STATUS, 32'h0000001E);
        uop(1'b0, SH_AC, 2'h1, 1'b1, 16'h0000);
        uop(1'b0, SH_AC, 2'h1, 1'b1, 16'h0000);
        rdchk("ac_shift_zero_fill", bsc_pkg::ADR_AC, 32'h00002000);
        chk("tf_low_zero", 32'h1, {31'h0, tf_q});
        wr(bsc_pkg::ADR_T, 16'h0002);
        uop(1'b0, SH_T, 2'h1, 1'b1, 16'h0000);
        rdchk("t_shift", bsc_pkg::ADR_T, 32'h00000001);
        rdchk("ac_untouched", bsc_pkg::ADR_AC, 32'h00002000);
        uop(1'b1, SH_T, 2'h1, 1'b1, 16'h0000);
        rdchk("t_cond_clock", bsc_pkg::ADR_T, 32'h00000001);
        chk("tf_cond_clock", 32'h0, {31'h0, tf_q});
        rdchk("status_cond", bsc_pkg::ADR_STATUS, 32'h0000000E);
        wr(bsc_pkg::ADR_AC, 16'h8181);
        uop(1'b0, SH_AC, 2'h2, 1'b0, 16'h0000);
        rdchk("ac_left_shift", bsc_pkg::ADR_AC, 32'h0000C081);
        chk("tf_left_lsb", 32'h0, {31'h0, tf_q});
        rdchk("status_left", bsc_pkg::ADR_STATUS, 32'h00000016);
        uop(1'b0, SH_AC, 2'h3, 1'b1, 16'h0000);
        rdchk("ac_right_shift", bsc_pkg::ADR_AC, 32'h0000C040);
        chk("tf_right_lsb", 32'h0, {31'h0, tf_q});
        wr(bsc_pkg::ADR_AC, 16'h00F3);
        uop(1'b0, SH_AC, 2'h1, 1'b1, 16'h000F);
        rdchk("ac_masked_shift", bsc_pkg::ADR_AC, 32'h00000001);
        wr(bsc_pkg::ADR_AC, 16'h12FF);
        uop(1'b0, AD_AC, 2'h3, 1'b1, 16'h0001);
        rdchk("ac_right_add", bsc_pkg::ADR_AC, 32'h00001200);
        chk("tf_right_carry", 32'h1, {31'h0, tf_q});
        rdchk("status_right", bsc_pkg::ADR_STATUS, 32'h00000019);
        uop(1'b0, AD_AC, 2'h3, 1'b0, 16'h00FE);
        rdchk("ac_right_cin", bsc_pkg::ADR_AC, 32'h000012FF);
        chk("tf_right_nocarry", 32'h0, {31'h0, tf_q});
        wr(bsc_pkg::ADR_AC, 16'hFF34);
        uop(1'b0, AD_AC, 2'h2, 1'b0, 16'h0000);
        rdchk("ac_left_cin", bsc_pkg::ADR_AC, 32'h00000034);
        chk("tf_left_carry", 32'h1, {31'h0, tf_q});
        wr(bsc_pkg::ADR_AC, 16'h00FF);
        uop(1'b0, AD_AC, 2'h0, 1'b1, 16'h0001);
        rdchk("ac_word_add", bsc_pkg::ADR_AC, 32'h00000100);
        chk("tf_word_nocarry", 32'h0, {31'h0, tf_q});
        wr(bsc_pkg::ADR_AC, 16'hFFFF);
        uop(1'b0, AD_AC, 2'h0, 1'b0, 16'h0000);
        rdchk("ac_word_wrap", bsc_pkg::ADR_AC, 32'h00000000);
        chk("tf_word_carry", 32'h1, {31'h0, tf_q});
        // frozen steps must leave registers and test flop alone
        wr(bsc_pkg::ADR_AC, 16'h0001);
        wr(bsc_pkg::ADR_CTRL, 16'h0001);
        uop(1'b0, SH_AC, 2'h1, 1'b0, 16'h0000);
        rdchk("ac_hold", bsc_pkg::ADR_AC, 32'h00000001);
        chk("tf_hold", 32'h1, {31'h0, tf_q});
        rdchk("ctrl_hold", bsc_pkg::ADR_CTRL, 32'h00000001);
        wr(bsc_pkg::ADR_CTRL, 16'h0000);
        uop(1'b0, SH_AC, 2'h1, 1'b0, 16'h0000);
        rdchk("ac_after_hold", bsc_pkg::ADR_AC, 32'h00008000);
        chk("tf_after_hold", 32'h0, {31'h0, tf_q});
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("ac_mid_reset", bsc_pkg::ADR_AC, 32'h00000000);
        rdchk("status_mid_reset", bsc_pkg::ADR_STATUS, 32'h0000001C);
        end_sim();
    end
endmodule
